/* File: inc/sfc_cfg.svh */
// Purpose: shared constants for the serial flash command link ends
// Assumes: included by bare name from modules; the package does not include it
// Notes: opcodes, status bit positions and timing counts
`ifndef SFC_CFG_SVH
`define SFC_CFG_SVH

// ----------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------
`define SFC_OP_SET_WL 8'h06
`define SFC_OP_CLR_WL 8'h04
`define SFC_OP_ST_RD 8'h05
`define SFC_OP_ST_WR 8'h01
`define SFC_OP_DUAL_RD 8'h3B
`define SFC_OP_PARAM_RD 8'h5A
`define SFC_OP_SEC_ER 8'h20
`define SFC_OP_BLK_ER_A 8'h52
`define SFC_OP_BLK_ER_B 8'hD8
`define SFC_OP_CHIP_ER_A 8'h60
`define SFC_OP_CHIP_ER_B 8'hC7
`define SFC_OP_PAGE_PROG 8'h02
`define SFC_OP_PWR_DOWN 8'hB9
`define SFC_OP_PWR_REL 8'hAB
`define SFC_OP_ID_RD 8'h90

// ----------------------------------------------------------------------
// status bit positions
// ----------------------------------------------------------------------
`define SFC_ST_BUSY 0
`define SFC_ST_WL 1
`define SFC_ST_PL_LO 2
`define SFC_ST_PL_HI 3
`define SFC_ST_LOCK 7

// ----------------------------------------------------------------------
// byte counts and values
// ----------------------------------------------------------------------
`define SFC_ADDR_BYTES 3
`define SFC_ID_ORDER_MAKER 8'h00
`define SFC_ID_ORDER_DEV 8'h01
`define SFC_BUSY_CYCLES 16'h0040
`define SFC_SCK_HALF 8'h0F

`endif

/* File: inc/sfc_pkg.sv */
// Purpose: types imported by both link ends, used by the host only
// Assumes: sfc_cfg.svh holds the numbers
// Notes: types only
package sfc_pkg;
	typedef enum logic [1:0] {SFC_IDLE, SFC_CMD, SFC_ARG, SFC_OUT}
		sfc_phase_t;
endpackage

/* File: inc/sfc_link_if.sv */
// Purpose: serial link between host controller and flash end
// Assumes: host makes sck from its own clock
// Notes: data_out pins have enables; host reads miso directly, ignoring miso_oe
`timescale 1ns/100ps
interface sfc_link_if;
	logic sck;
	logic cs_n;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic io1;
	logic io1_oe;
	logic wp_n;
	modport flash (input sck, input cs_n, input mosi, input wp_n,
		output miso, output miso_oe, output io1, output io1_oe);
	modport host (output sck, output cs_n, output mosi, output wp_n,
		input miso, input miso_oe, input io1, input io1_oe);
endinterface

/* File: rtl/sfc_flash.sv */
// Purpose: flash end: command decode, write latch and status register
// Assumes: sck, cs_n, mosi, wp_n asynchronous; sampled by clk
// Notes: array datapath absent; read data is a fixed pattern
//
// Behaviour
// R1: 5A param read, 3B dual read, addr+dummy
// R2: 20 sector, 52/D8 block, 60/C7 chip erase
// R3: 02 program, B9 power-down, AB release/signature
// R4: 90 id read, order byte picks first
// R5: host avoids undefined opcodes
// R6: 06 sets write latch
// R7: host sets latch before each write command
// R8: 04 clears write latch
// R9: latch cleared on reset and write commands
// R10: status read anytime, repeats while selected; code sends no status during power-down
// R11: host polls busy before new commands
// R12: busy flag in bit 0
// R13: write latch bit 1 gates write commands
// R14: protect level bits 2,3 via status write
// R15: protected area blocks program and erase
// R16: lock bit 7 with wp low blocks writes
// R17: writes need cs rise on byte boundary
// R18: sample rising edge, drive falling edge
// R19: status write keeps bits 6,5,1,0
// R20: unused status bits read zero
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "sfc_cfg.svh"
module sfc_flash
	import sfc_pkg::*;
#(
	parameter int BUSY_CYCLES = `SFC_BUSY_CYCLES,
	parameter logic [7:0] MAKER_ID = 8'hA5, // arbitrary value
	parameter logic [7:0] DEVICE_ID = 8'h3C // arbitrary value
)(
	input wire logic clk,
	input wire logic rst,
	sfc_link_if.flash link,
	output logic [7:0] status_q,
	output logic power_down_q,
	output logic [7:0] last_op_q
);
	initial begin
		if (BUSY_CYCLES < 1 || BUSY_CYCLES > 65535) begin
			$error("BUSY_CYCLES out of range");
		end
	end

	// ------------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------------
	logic [1:0] sck_s, cs_s, mosi_s, wp_s;
	logic sck_d1;
	// two flops each before any logic looks at the pins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sck_s <= 2'h0;
			cs_s <= 2'h3;
			mosi_s <= 2'h0;
			wp_s <= 2'h3;
			sck_d1 <= 1'b0;
		end else begin
			sck_s <= {sck_s[0], link.sck};
			cs_s <= {cs_s[0], link.cs_n};
			mosi_s <= {mosi_s[0], link.mosi};
			wp_s <= {wp_s[0], link.wp_n};
			sck_d1 <= sck_s[1];
		end
	end
	wire cs_n = cs_s[1];
	// R18: rising edge samples, falling edge drives
	wire sck_rise = sck_s[1] & ~sck_d1 & ~cs_n;
	wire sck_fall = ~sck_s[1] & sck_d1 & ~cs_n;
	logic cs_d1;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cs_d1 <= 1'b1;
		end else begin
			cs_d1 <= cs_n;
		end
	end
	wire frame_end = cs_n & ~cs_d1;

	// ------------------------------------------------------------------
	// shift-in and byte counting
	// ------------------------------------------------------------------
	logic [7:0] sh_q, op_q, arg3_q, stw_q;
	logic [2:0] bit_q;
	logic [3:0] nbyte_q;
	wire [7:0] sh_d = {sh_q[6:0], mosi_s[1]};
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sh_q <= 8'h00;
			bit_q <= 3'h0;
			nbyte_q <= 4'h0;
			op_q <= 8'h00;
			arg3_q <= 8'h00;
			stw_q <= 8'h00;
		end else if (cs_n) begin
			bit_q <= 3'h0;
			if (frame_end == 1'b0) begin
				nbyte_q <= 4'h0;
			end
		end else if (sck_rise) begin
			sh_q <= sh_d;
			bit_q <= bit_q + 3'h1;
			if (bit_q == 3'h7) begin
				if (nbyte_q != 4'hF) begin
					nbyte_q <= nbyte_q + 4'h1;
				end
				if (nbyte_q == 4'h0) begin
					op_q <= sh_d;
				end
				if (nbyte_q == 4'h1) begin
					stw_q <= sh_d;
				end
				if (nbyte_q == 4'(`SFC_ADDR_BYTES)) begin
					arg3_q <= sh_d;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// command execution at frame end
	// ------------------------------------------------------------------
	function automatic logic is_write_op(input logic [7:0] op);
		is_write_op = op == `SFC_OP_ST_WR || op == `SFC_OP_PAGE_PROG ||
			op == `SFC_OP_SEC_ER || op == `SFC_OP_BLK_ER_A ||
			op == `SFC_OP_BLK_ER_B || op == `SFC_OP_CHIP_ER_A ||
			op == `SFC_OP_CHIP_ER_B;
	endfunction
	// R17: only whole bytes count for control commands
	wire on_bound = bit_q == 3'h0;
	wire [3:0] want = (op_q == `SFC_OP_ST_WR) ? 4'h2 :
		(op_q == `SFC_OP_PAGE_PROG || op_q == `SFC_OP_SEC_ER ||
		op_q == `SFC_OP_BLK_ER_A || op_q == `SFC_OP_BLK_ER_B) ? 4'h4 :
		4'h1;
	wire len_ok = on_bound && (op_q == `SFC_OP_PAGE_PROG ?
		nbyte_q >= want : nbyte_q == want);
	wire busy = status_q[`SFC_ST_BUSY];
	wire wl = status_q[`SFC_ST_WL];
	wire [1:0] pl = status_q[`SFC_ST_PL_HI:`SFC_ST_PL_LO];
	// R16: lock with wp low refuses status writes
	wire hw_lock = status_q[`SFC_ST_LOCK] & ~wp_s[1];
	// R15: block 3 at level 1, blocks 2-3 at level 2, all at 3
	wire [1:0] blk = arg3_q[1:0];
	wire area_prot = (pl == 2'h3) || (pl == 2'h2 && blk[1]) ||
		(pl == 2'h1 && blk == 2'h3);
	logic [15:0] busy_cnt_q;
	logic go_write;
	always_comb begin
		go_write = 1'b0;
		if (frame_end && len_ok && wl && !busy && !power_down_q) begin
			case (op_q)
				`SFC_OP_ST_WR: go_write = !hw_lock;
				`SFC_OP_CHIP_ER_A, `SFC_OP_CHIP_ER_B: go_write = pl == 2'h0;
				`SFC_OP_PAGE_PROG, `SFC_OP_SEC_ER, `SFC_OP_BLK_ER_A,
					`SFC_OP_BLK_ER_B: go_write = !area_prot;
				default: go_write = 1'b0;
			endcase
		end
	end
	wire exec = frame_end && len_ok;
	// status register; R20: bits 6..4 held at zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status_q <= 8'h00;
			busy_cnt_q <= 16'h0000;
			last_op_q <= 8'h00;
		end else begin
			// reads may end after any bit, so any whole opcode counts
			if (frame_end && nbyte_q != 4'h0) begin
				last_op_q <= op_q;
			end
			// R12: busy while a timed cycle runs
			if (go_write) begin
				status_q[`SFC_ST_BUSY] <= 1'b1;
				busy_cnt_q <= 16'(BUSY_CYCLES);
			end else if (busy_cnt_q != 16'h0000) begin
				busy_cnt_q <= busy_cnt_q - 16'h0001;
				// R9: latch drops when the cycle completes
				if (busy_cnt_q == 16'h0001) begin
					status_q[`SFC_ST_BUSY] <= 1'b0;
					status_q[`SFC_ST_WL] <= 1'b0;
				end
			end
			// R13: write commands run only while latch is set
			// R14: protect levels change only by status write
			// R19: other bits kept on status write
			if (go_write && op_q == `SFC_OP_ST_WR) begin
				status_q[`SFC_ST_LOCK] <= stw_q[`SFC_ST_LOCK];
				status_q[`SFC_ST_PL_HI] <= stw_q[`SFC_ST_PL_HI];
				status_q[`SFC_ST_PL_LO] <= stw_q[`SFC_ST_PL_LO];
			end
			if (exec && !busy && !power_down_q) begin
				// R6: set latch
				if (op_q == `SFC_OP_SET_WL) begin
					status_q[`SFC_ST_WL] <= 1'b1;
				end
				// R8: clear latch
				if (op_q == `SFC_OP_CLR_WL) begin
					status_q[`SFC_ST_WL] <= 1'b0;
				end
				if (is_write_op(op_q) && !go_write) begin
					status_q[`SFC_ST_WL] <= 1'b0;
				end
			end
		end
	end
	// R3: power-down entry and release
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			power_down_q <= 1'b0;
		end else if (exec && !busy) begin
			if (op_q == `SFC_OP_PWR_DOWN) begin
				power_down_q <= 1'b1;
			end else if (op_q == `SFC_OP_PWR_REL) begin
				power_down_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// output shifting on falling sck
	// ------------------------------------------------------------------
	// R1 R3 R4 R10: number of header bytes before data goes out
	function automatic logic [3:0] hdr_len(input logic [7:0] op);
		case (op)
			`SFC_OP_ST_RD: hdr_len = 4'h1;
			`SFC_OP_PARAM_RD, `SFC_OP_DUAL_RD: hdr_len = 4'h5;
			`SFC_OP_PWR_REL, `SFC_OP_ID_RD: hdr_len = 4'h4;
			default: hdr_len = 4'hF;
		endcase
	endfunction
	logic [7:0] out_q, load_b;
	logic out_en_q, id_sel_q, miso_q, io1_q;
	wire [3:0] hdr = hdr_len(op_q);
	wire rd_ok = !busy || op_q == `SFC_OP_ST_RD;
	wire rd_allowed = rd_ok && (!power_down_q || op_q == `SFC_OP_PWR_REL);
	wire dual = op_q == `SFC_OP_DUAL_RD;
	// R10 R4: next byte to send; status is fetched afresh each byte
	always_comb begin
		case (op_q)
			`SFC_OP_ST_RD: load_b = status_q;
			`SFC_OP_ID_RD: load_b = ((arg3_q == `SFC_ID_ORDER_DEV) ^
				id_sel_q) ? DEVICE_ID : MAKER_ID;
			`SFC_OP_PWR_REL: load_b = DEVICE_ID;
			default: load_b = 8'hFF;
		endcase
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_q <= 8'h00;
			out_en_q <= 1'b0;
			id_sel_q <= 1'b0;
			miso_q <= 1'b0;
			io1_q <= 1'b0;
		end else if (cs_n) begin
			out_en_q <= 1'b0;
			id_sel_q <= 1'b0;
		end else if (sck_fall && nbyte_q >= hdr && hdr != 4'hF &&
			rd_allowed) begin
			out_en_q <= 1'b1;
			// byte start: first bit goes out before the first data rise
			if (dual ? bit_q[1:0] == 2'h0 : bit_q == 3'h0) begin
				if (op_q == `SFC_OP_ID_RD) begin
					id_sel_q <= ~id_sel_q;
				end
				if (dual) begin
					io1_q <= load_b[7];
					miso_q <= load_b[6];
					out_q <= {load_b[5:0], 2'h3};
				end else begin
					miso_q <= load_b[7];
					out_q <= {load_b[6:0], 1'b0};
				end
			end else if (dual) begin
				io1_q <= out_q[7];
				miso_q <= out_q[6];
				out_q <= {out_q[5:0], 2'h3};
			end else begin
				miso_q <= out_q[7];
				out_q <= {out_q[6:0], 1'b0};
			end
		end
	end
	assign link.miso = miso_q;
	assign link.miso_oe = out_en_q;
	assign link.io1 = io1_q;
	assign link.io1_oe = out_en_q & dual;
endmodule // sfc_flash

/* File: rtl/sfc_host.sv */
// Purpose: host controller: frames commands onto the link
// Assumes: apb slave for orders, sck made by divider of clk
// Notes: mode 0 only; R5 R7 R11 left to software
`timescale 1ns/100ps
`include "sfc_cfg.svh"
module sfc_host
	import sfc_pkg::*;
#(
	parameter logic [7:0] SCK_HALF = `SFC_SCK_HALF
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	sfc_link_if.host link
);
	initial begin
		// answer needs about five clk after a fall to pass both syncs
		if (SCK_HALF < 8'h05) begin
			$error("SCK_HALF too short for the answer round trip");
		end
	end
	// ------------------------------------------------------------------
	// registers: 0x0 ctrl (w: [7:0] op,[31:24] byte count incl op;
	// r: [0] busy), 0x4 addr/args, 0x8 last received byte rd, 0xC wp pin
	// ------------------------------------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00, A_ARGS = 8'h04, A_RX = 8'h08;
	localparam logic [7:0] A_WP = 8'h0C;
	logic [31:0] args_q;
	logic [63:0] tx_q;
	logic [7:0] rx_q, nbits_q, div_q;
	logic [11:0] left_q;
	logic busy_q, sck_q, cs_q, mosi_q, wp_q;
	sfc_phase_t ph_q;
	logic [1:0] miso_s;
	// two flops before the answer pin is read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			miso_s <= 2'h0;
		end else begin
			miso_s <= {miso_s[0], link.miso};
		end
	end
	wire acc = psel & penable;
	wire start = acc & pwrite & paddr == A_CTRL & !busy_q;
	// apb: answer in the access cycle, zero wait
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			args_q <= 32'h0000_0000;
			wp_q <= 1'b1;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & paddr[7:4] != 4'h0;
			if (psel & ~penable & ~pwrite) begin
				case (paddr)
					A_CTRL: prdata <= {31'h0, busy_q};
					A_RX: prdata <= {24'h0, rx_q};
					A_WP: prdata <= {31'h0, wp_q};
					default: prdata <= 32'h0000_0000;
				endcase
			end
			if (acc & pwrite & paddr == A_ARGS) begin
				args_q <= pwdata;
			end
			if (acc & pwrite & paddr == A_WP) begin
				wp_q <= pwdata[0];
			end
		end
	end
	// frame engine: sck divider, shift on falling, sample on rising
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_q <= 1'b0;
			sck_q <= 1'b0;
			cs_q <= 1'b1;
			mosi_q <= 1'b0;
			tx_q <= 64'h0;
			rx_q <= 8'h00;
			div_q <= 8'h00;
			left_q <= 12'h000;
			ph_q <= SFC_IDLE;
			nbits_q <= 8'h00;
		end else begin
			case (ph_q)
				SFC_IDLE: if (start) begin
					busy_q <= 1'b1;
					cs_q <= 1'b0;
					tx_q <= {pwdata[7:0], args_q, 24'h0};
					left_q <= {pwdata[31:24], 3'h0} + 12'h000;
					mosi_q <= pwdata[7];
					div_q <= SCK_HALF;
					ph_q <= SFC_CMD;
				end
				SFC_CMD: if (div_q != 8'h00) begin
					div_q <= div_q - 8'h01;
				end else begin
					div_q <= SCK_HALF;
					sck_q <= ~sck_q;
					if (!sck_q) begin
						rx_q <= {rx_q[6:0], miso_s[1]};
						left_q <= left_q - 12'h001;
					end else if (left_q == 12'h000) begin
						ph_q <= SFC_OUT;
						sck_q <= 1'b0;
					end else begin
						tx_q <= {tx_q[62:0], 1'b0};
						mosi_q <= tx_q[62];
					end
				end
				SFC_OUT: if (div_q != 8'h00) begin
					div_q <= div_q - 8'h01;
				end else begin
					cs_q <= 1'b1;
					busy_q <= 1'b0;
					ph_q <= SFC_IDLE;
				end
				default: ph_q <= SFC_IDLE;
			endcase
		end
	end
	assign link.sck = sck_q;
	assign link.cs_n = cs_q;
	assign link.mosi = mosi_q;
	assign link.wp_n = wp_q;
endmodule // sfc_host

/* File: verif/sfc_link_properties.sv */
// Purpose: wire-level checks on the link between host and flash ends
// Assumes: host runs mode 0 and makes sck by dividing clk
// Notes: watches only link signals, never the user sides
`timescale 1ns/100ps
module sfc_link_properties #(
	parameter logic [7:0] SCK_HALF = 8'h0F
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe,
	input wire logic io1,
	input wire logic io1_oe,
	input wire logic wp_n
);
	logic sck_q;
	logic [7:0] hi_q;
	logic [15:0] bits_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// sck history and length of the current high phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sck_q <= 1'b0;
			hi_q <= 8'h00;
		end else begin
			sck_q <= sck;
			hi_q <= sck ? hi_q + 8'h01 : 8'h00;
		end
	end

	// rising sck edges in this frame; cleared while deselected
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			bits_q <= 16'h0000;
		else if (cs_n)
			bits_q <= 16'h0000;
		else if (sck && !sck_q)
			bits_q <= bits_q + 16'h0001;
	end

	// ----------------------------------------------------------------
	// link timing and framing
	// ----------------------------------------------------------------
	AST_SCK_IDLE_LOW: assert property (cs_n |-> !sck)
		else $error("sck high while deselected");
	AST_CS_FALL_SETUP: assert property ($fell(cs_n) |-> !sck [*2])
		else $error("sck rose too soon after select");
	AST_SCK_HIGH_LEN: assert property (
		$fell(sck) |-> hi_q == SCK_HALF + 8'h01)
		else $error("sck high phase has wrong length");
	AST_MOSI_HOLD: assert property ($rose(sck) |-> $stable(mosi))
		else $error("mosi moved at sampling edge");
	AST_MISO_AT_LOW: assert property (
		!cs_n && miso_oe && $changed(miso) |-> !sck)
		else $error("miso changed while sck high");
	AST_BYTE_FRAME: assert property (
		$rose(cs_n) |-> bits_q[2:0] == 3'h0)
		else $error("frame ended off a byte boundary");
	AST_OE_IDLE: assert property (
		cs_n [*4] |-> !miso_oe && !io1_oe)
		else $error("output enabled while deselected");
	AST_NO_OE_OPCODE: assert property (
		!cs_n && bits_q < 16'h0008 |-> !miso_oe && !io1_oe)
		else $error("output enabled during opcode byte");
	AST_IO1_DUAL_ONLY: assert property (io1_oe |-> miso_oe)
		else $error("second line driven without first");

	// main scenarios reached
	cover property ($rose(io1_oe));
	cover property ($rose(miso_oe));
	cover property ($rose(cs_n) && bits_q == 16'h0020);
endmodule // sfc_link_properties

/* File: verif/tb_serial_flash_command_status.sv */
// Purpose: drives the host over apb and checks both link ends
// Assumes: short sck half period for run time; busy count long enough for a status read to see busy
// Notes: flash user side observed directly on its status ports
`timescale 1ns/100ps
`include "sfc_cfg.svh"
module tb_serial_flash_command_status
	import sfc_pkg::*;
;
	localparam logic [7:0] MAKER = 8'h5E; // arbitrary value
	localparam logic [7:0] DEVID = 8'hC3; // arbitrary value
	logic clk, rst, psel, penable, pwrite, pready, pslverr, slv;
	logic power_down_q;
	logic [7:0] paddr, status_q, last_op_q;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] ers [4] = '{8'h20, 8'h52, 8'hD8, 8'h02};
	int err_total, checks;

	sfc_link_if lnk();
	sfc_host #(.SCK_HALF(8'h07)) sfc_host_i (.clk(clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(lnk));
	sfc_flash #(.BUSY_CYCLES(400), .MAKER_ID(MAKER), .DEVICE_ID(DEVID))
		sfc_flash_i (.clk(clk), .rst(rst), .link(lnk),
		.status_q(status_q), .power_down_q(power_down_q),
		.last_op_q(last_op_q));
	sfc_link_properties #(.SCK_HALF(8'h07)) sfc_link_properties_i (
		.clk(clk), .rst(rst), .sck(lnk.sck), .cs_n(lnk.cs_n),
		.mosi(lnk.mosi), .miso(lnk.miso), .miso_oe(lnk.miso_oe),
		.io1(lnk.io1), .io1_oe(lnk.io1_oe), .wp_n(lnk.wp_n));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one apb transfer; an idle edge follows so strobes never re-rise
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic frame(input logic [7:0] op, input logic [7:0] n,
		input logic [31:0] args);
		int k;
		apb(1'b1, 8'h04, args);
		apb(1'b1, 8'h00, {n, 16'h0000, op});
		k = 0;
		do begin
			apb(1'b0, 8'h00, 32'h0);
			k++;
		end while (rd[0] !== 1'b0 && k < 1000);
		if (rd[0] !== 1'b0) begin
			err_total++;
			$display("ERROR t=%0t busy=%h exp=%h", $time, rd[0], 1'b0);
		end
		apb(1'b0, 8'h08, 32'h0);
	endtask

	// status read over the link; leaves the byte in rd
	task automatic st_rd();
		frame(`SFC_OP_ST_RD, 8'h02, 32'h0);
	endtask

	// latch, command, busy seen over link, then final status
	task automatic wcmd(input logic [7:0] op, input logic [7:0] n,
		input logic [31:0] args, input logic [7:0] run,
		input logic [7:0] fin);
		int k;
		frame(`SFC_OP_SET_WL, 8'h01, 32'h0);
		frame(op, n, args);
		st_rd();
		chk8(rd[7:0] & 8'h03, run);
		k = 0;
		while (status_q[`SFC_ST_BUSY] !== 1'b0 && k < 1000) begin
			@(posedge clk);
			k++;
		end
		chk8(status_q, fin);
	endtask

	task automatic conclude();
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		#300000;
		err_total++;
		conclude();
	end

	initial begin
		err_total = 0;
		checks = 0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk8(status_q, 8'h00);
		apb(1'b0, 8'h10, 32'h0);
		chk8({7'h00, slv}, 8'h01);
		frame(`SFC_OP_SET_WL, 8'h01, 32'h0);
		st_rd();
		chk8(rd[7:0], 8'h02);
		frame(`SFC_OP_CLR_WL, 8'h01, 32'h0);
		st_rd();
		chk8(rd[7:0], 8'h00);
		frame(`SFC_OP_ST_WR, 8'h02, {8'h8C, 24'h0});
		st_rd();
		chk8(rd[7:0], 8'h00);
		$display("test latch done");
		wcmd(`SFC_OP_ST_WR, 8'h02, {8'hFF, 24'h0}, 8'h03, 8'h8C);
		apb(1'b1, 8'h0C, 32'h0);
		wcmd(`SFC_OP_ST_WR, 8'h02, 32'h0, 8'h00, 8'h8C);
		apb(1'b1, 8'h0C, 32'h1);
		wcmd(`SFC_OP_ST_WR, 8'h02, {8'h04, 24'h0}, 8'h03, 8'h04);
		$display("test status write done");
		for (int i = 0; i < 4; i++) begin
			wcmd(ers[i], 8'h04, 32'h0000_0300, 8'h00, 8'h04);
			wcmd(ers[i], 8'h04, 32'h0000_0000, 8'h03, 8'h04);
		end
		wcmd(`SFC_OP_CHIP_ER_A, 8'h01, 32'h0, 8'h00, 8'h04);
		wcmd(`SFC_OP_ST_WR, 8'h02, 32'h0, 8'h03, 8'h00);
		wcmd(`SFC_OP_CHIP_ER_A, 8'h01, 32'h0, 8'h03, 8'h00);
		wcmd(`SFC_OP_CHIP_ER_B, 8'h01, 32'h0, 8'h03, 8'h00);
		$display("test erase program done");
		frame(`SFC_OP_PWR_DOWN, 8'h01, 32'h0);
		chk8({7'h00, power_down_q}, 8'h01);
		frame(`SFC_OP_PWR_REL, 8'h05, 32'h0);
		chk8(rd[7:0], DEVID);
		chk8({7'h00, power_down_q}, 8'h01);
		frame(`SFC_OP_PWR_REL, 8'h01, 32'h0);
		chk8({7'h00, power_down_q}, 8'h00);
		frame(`SFC_OP_DUAL_RD, 8'h06, 32'h0);
		chk8(rd[7:0], 8'hFF);
		chk8(last_op_q, `SFC_OP_DUAL_RD);
		frame(`SFC_OP_PARAM_RD, 8'h06, 32'h0);
		chk8(rd[7:0], 8'hFF);
		chk8(last_op_q, `SFC_OP_PARAM_RD);
		frame(`SFC_OP_ID_RD, 8'h05, 32'h0);
		chk8(rd[7:0], MAKER);
		frame(`SFC_OP_ID_RD, 8'h05, 32'h0000_0100);
		chk8(rd[7:0], DEVID);
		$display("test reads done");
		conclude();
	end
endmodule // tb_serial_flash_command_status
